// ### common/sbl_defines.vh
// Constants for the serial boot loader sequencer
`ifndef SBL_DEFINES_VH
`define SBL_DEFINES_VH
// Register byte offsets on the AXI4-Lite bus
`define SBL_OFS_CTRL 4'h0
`define SBL_OFS_STATUS 4'h4
`define SBL_OFS_RELOAD 4'h8
`define SBL_OFS_MEASURE 4'hc
// Control register fields
`define SBL_CTRL_SWRST 0
`define SBL_CTRL_BIDIR 1
`define SBL_CTRL_OVFCLR 2
// AXI responses
`define SBL_RESP_OKAY 2'h0
`define SBL_RESP_SLVERR 2'h2
// Forced configuration values in UART boot
`define SBL_SYSCFG_VAL 16'h0400
`define SBL_CONTEXT_VAL 16'hfa00
`define SBL_STACK_TOP_VAL 16'hfa40
`define SBL_STACK_UNDER_VAL 16'hfa00
`define SBL_STACK_OVER_VAL 16'hfc00
`define SBL_SCON_VAL 16'h8011
// Memory addresses
`define SBL_RAM_BASE 24'h00fa40
`define SBL_RESET_VEC 24'h000000
// Byte counts
`define SBL_UART_BYTES 8'h20
`define SBL_CAN_BYTES 8'h80
// Baud measurement arithmetic
`define SBL_MEAS_PRESC 2'h3
`define SBL_MEAS_OFFSET 16'h0024
`define SBL_MEAS_DIV 16'h0048
`define SBL_BIT_MULT 5
// Timing
`define SBL_CLK_MHZ 250
`define SBL_TXDLY_NS 1300000
`define SBL_TXDLY_CYC ((`SBL_TXDLY_NS * `SBL_CLK_MHZ + 999) / 1000)
`endif

// ### rtl/sbl_top.v
// Serial boot loader sequencer with AXI4-Lite status and control
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sbl_defines.vh"
module sbl_top #(
  parameter TXDLY_CYC = `SBL_TXDLY_CYC,
  parameter [7:0] ACK_CODE = 8'ha5 // Arbitrary value
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire boot_select_pin,
  input wire external_access_select,
  input wire serial_receive_pin,
  input wire can_receive_pin,
  output reg serial_transmit_pin,
  output reg serial_transmit_oe,
  output reg boot_loader_mode,
  output wire watchdog_enable,
  output wire fetch_redirect,
  output reg ram_wr_en,
  output reg [23:0] ram_wr_addr,
  output reg [7:0] ram_wr_data,
  output reg jump_req,
  output reg [23:0] jump_addr,
  output reg exec_start,
  output reg exec_from_external,
  output reg can_boot_start,
  output reg [15:0] system_config_reg,
  output reg [15:0] context_base_pointer,
  output reg [15:0] stack_top_pointer,
  output reg [15:0] stack_underflow_limit,
  output reg [15:0] stack_overflow_limit,
  output reg [15:0] serial_control_reg,
  output reg [15:0] baud_generator_reg,
  output reg tx_direction_bit
);
  localparam ST_OFF = 9'h001;
  localparam ST_WAIT = 9'h002;
  localparam ST_MEAS = 9'h004;
  localparam ST_DLY = 9'h008;
  localparam ST_ACK = 9'h010;
  localparam ST_LOAD = 9'h020;
  localparam ST_JUMP = 9'h040;
  localparam ST_RUN = 9'h080;
  localparam ST_CAN = 9'h100;

  // Reload from measured count, clamped at zero for very short bytes
  function [15:0] calc_reload;
    input [15:0] count;
    begin
      if (count < `SBL_MEAS_OFFSET) begin
        calc_reload = 16'h0000;
      end else begin
        calc_reload = (count - `SBL_MEAS_OFFSET) / `SBL_MEAS_DIV;
      end
    end
  endfunction

  // Bit period in clocks: 32 * (reload + 1)
  function [20:0] bit_period;
    input [15:0] rl;
    begin
      bit_period = {5'h00, rl + 16'h0001} << `SBL_BIT_MULT;
    end
  endfunction

  // Two-flop synchronisers; only the second stage is read
  reg [1:0] bsel_sync, xacc_sync, rx_sync, can_sync;
  reg rx_prev, can_prev;
  always @(posedge aclk) begin
    bsel_sync <= {bsel_sync[0], boot_select_pin};
    xacc_sync <= {xacc_sync[0], external_access_select};
    rx_sync <= {rx_sync[0], serial_receive_pin};
    can_sync <= {can_sync[0], can_receive_pin};
  end
  wire bsel_s = bsel_sync[1];
  wire xacc_s = xacc_sync[1];
  wire rx_s = rx_sync[1];
  wire can_s = can_sync[1];
  wire rx_fall = rx_prev & ~rx_s;
  wire rx_rise = ~rx_prev & rx_s;
  wire can_fall = can_prev & ~can_s;

  // AXI4-Lite write channel state
  reg aw_held, w_held;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg w_lane0_reg;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire ctrl_wr = wr_fire & (aw_addr_reg == `SBL_OFS_CTRL) & w_lane0_reg;
  wire sw_reset = ctrl_wr & w_data_reg[`SBL_CTRL_SWRST];
  wire sw_bidir = w_data_reg[`SBL_CTRL_BIDIR];
  wire ovf_clr = ctrl_wr & w_data_reg[`SBL_CTRL_OVFCLR];

  // Sequencer state
  reg [8:0] state_reg;
  reg strap_pending;
  reg ovf_flag;
  reg [1:0] presc;
  reg [15:0] meas_cnt;
  reg [15:0] meas_last;
  reg [20:0] period;
  reg [20:0] tmr;
  reg [3:0] bit_cnt;
  reg [9:0] tx_shift;
  reg [7:0] rx_shift;
  reg rx_busy;
  reg [7:0] byte_cnt;

  // Mode flags derived from the latched mode
  assign watchdog_enable = ~boot_loader_mode;
  assign fetch_redirect = boot_loader_mode;

  // Write address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        // Upper address bits must be clear; 4'h1 is unaligned and so marks unmapped
        aw_addr_reg <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'h1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the control word is writable; the rest answer with an error
        s_axi_bresp <= (aw_addr_reg == `SBL_OFS_CTRL) ? `SBL_RESP_OKAY : `SBL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle answer from live state
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SBL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SBL_RESP_OKAY;
      // Addresses above the map must not alias onto the low registers
      case ((s_axi_araddr[31:4] == 28'h0000000) ? s_axi_araddr[3:0] : 4'h1)
        `SBL_OFS_CTRL: begin
          s_axi_rdata <= 32'h0000_0000;
        end
        `SBL_OFS_STATUS: begin
          s_axi_rdata <= {7'h00, state_reg, byte_cnt, 5'h00,
                          ovf_flag, exec_from_external, boot_loader_mode};
        end
        `SBL_OFS_RELOAD: begin
          s_axi_rdata <= {16'h0000, baud_generator_reg};
        end
        `SBL_OFS_MEASURE: begin
          s_axi_rdata <= {16'h0000, meas_last};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SBL_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Boot sequence; strap is caught on the first clock after reset release
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_OFF;
      strap_pending <= 1'b1;
      boot_loader_mode <= 1'b0;
      exec_from_external <= 1'b0;
      exec_start <= 1'b0;
      ovf_flag <= 1'b0;
      rx_prev <= 1'b1;
      can_prev <= 1'b1;
      presc <= 2'h0;
      meas_cnt <= 16'h0000;
      meas_last <= 16'h0000;
      period <= 21'h000000;
      tmr <= 21'h000000;
      bit_cnt <= 4'h0;
      tx_shift <= 10'h3ff;
      rx_shift <= 8'h00;
      rx_busy <= 1'b0;
      byte_cnt <= 8'h00;
      serial_transmit_pin <= 1'b1;
      serial_transmit_oe <= 1'b0;
      ram_wr_en <= 1'b0;
      ram_wr_addr <= `SBL_RAM_BASE;
      ram_wr_data <= 8'h00;
      jump_req <= 1'b0;
      jump_addr <= `SBL_RAM_BASE;
      can_boot_start <= 1'b0;
      system_config_reg <= 16'h0000;
      context_base_pointer <= 16'h0000;
      stack_top_pointer <= 16'h0000;
      stack_underflow_limit <= 16'h0000;
      stack_overflow_limit <= 16'h0000;
      serial_control_reg <= 16'h0000;
      baud_generator_reg <= 16'h0000;
      tx_direction_bit <= 1'b0;
    end else begin
      rx_prev <= rx_s;
      can_prev <= can_s;
      ram_wr_en <= 1'b0;
      jump_req <= 1'b0;
      exec_start <= 1'b0;
      can_boot_start <= 1'b0;
      // Sticky overflow: a new overflow beats a clear in the same cycle
      if (ovf_clr) begin
        ovf_flag <= 1'b0;
      end
      if (strap_pending || (sw_reset && sw_bidir && exec_from_external)) begin
        // Hardware reset, or degraded software reset: the pin is looked at
        strap_pending <= 1'b0;
        exec_from_external <= ~xacc_s;
        serial_transmit_oe <= 1'b0;
        serial_transmit_pin <= 1'b1;
        byte_cnt <= 8'h00;
        if (!bsel_s) begin
          boot_loader_mode <= 1'b1;
          state_reg <= ST_WAIT;
          system_config_reg <= `SBL_SYSCFG_VAL;
          context_base_pointer <= `SBL_CONTEXT_VAL;
          stack_top_pointer <= `SBL_STACK_TOP_VAL;
          stack_underflow_limit <= `SBL_STACK_UNDER_VAL;
          stack_overflow_limit <= `SBL_STACK_OVER_VAL;
        end else begin
          boot_loader_mode <= 1'b0;
          state_reg <= ST_OFF;
          exec_start <= 1'b1;
        end
      end else if (sw_reset) begin
        // Software reset, unless degraded, ignores the select pin and always leaves the mode
        boot_loader_mode <= 1'b0;
        state_reg <= ST_OFF;
        serial_transmit_oe <= 1'b0;
        serial_transmit_pin <= 1'b1;
        exec_start <= 1'b1;
      end else begin
        case (state_reg)
          ST_OFF: begin
            state_reg <= ST_OFF;
          end
          ST_WAIT: begin
            // Idle-high lines are assumed; a falling edge here starts a loader, serial before CAN
            if (rx_fall) begin
              state_reg <= ST_MEAS;
              presc <= 2'h0;
              meas_cnt <= 16'h0000;
            end else if (can_fall) begin
              state_reg <= ST_CAN;
              can_boot_start <= 1'b1;
            end
          end
          ST_MEAS: begin
            // Timer runs at a quarter of the clock across nine low bits
            presc <= presc + 2'h1;
            if (rx_rise) begin
              meas_last <= meas_cnt;
              baud_generator_reg <= calc_reload(meas_cnt);
              period <= bit_period(calc_reload(meas_cnt));
              serial_control_reg <= `SBL_SCON_VAL;
              tx_direction_bit <= 1'b1;
              serial_transmit_pin <= 1'b1;
              tmr <= 21'h000000;
              state_reg <= ST_DLY;
            end else if (presc == `SBL_MEAS_PRESC) begin
              if (meas_cnt == 16'hffff) begin
                ovf_flag <= 1'b1;
                state_reg <= ST_WAIT;
              end else begin
                meas_cnt <= meas_cnt + 16'h0001;
              end
            end
          end
          ST_DLY: begin
            // Pin stays undriven until the delay has run out
            if (tmr == TXDLY_CYC - 1) begin
              serial_transmit_oe <= 1'b1;
              tx_shift <= {1'b1, ACK_CODE, 1'b0};
              bit_cnt <= 4'h0;
              tmr <= 21'h000000;
              state_reg <= ST_ACK;
            end else begin
              tmr <= tmr + 21'h000001;
            end
          end
          ST_ACK: begin
            // LSB first, one bit per measured bit period
            serial_transmit_pin <= tx_shift[0];
            if (tmr == period - 21'h000001) begin
              tmr <= 21'h000000;
              tx_shift <= {1'b1, tx_shift[9:1]};
              if (bit_cnt == 4'h9) begin
                state_reg <= ST_LOAD;
                rx_busy <= 1'b0;
                byte_cnt <= 8'h00;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end else begin
              tmr <= tmr + 21'h000001;
            end
          end
          ST_LOAD: begin
            serial_transmit_pin <= 1'b1;
            if (!rx_busy) begin
              if (rx_fall) begin
                rx_busy <= 1'b1;
                bit_cnt <= 4'h0;
                tmr <= {1'b0, period[20:1]};
              end
            end else if (tmr == 21'h000000) begin
              // Sample at mid bit: start, eight data, stop
              tmr <= period - 21'h000001;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h0) begin
                if (rx_s) begin
                  rx_busy <= 1'b0; // Glitch, not a start bit
                end
              end else if (bit_cnt < 4'h9) begin
                rx_shift <= {rx_s, rx_shift[7:1]};
              end else begin
                rx_busy <= 1'b0;
                ram_wr_en <= 1'b1;
                ram_wr_addr <= `SBL_RAM_BASE + {16'h0000, byte_cnt};
                ram_wr_data <= rx_shift;
                byte_cnt <= byte_cnt + 8'h01;
                if (byte_cnt == `SBL_UART_BYTES - 8'h01) begin
                  state_reg <= ST_JUMP;
                end
              end
            end else begin
              tmr <= tmr - 21'h000001;
            end
          end
          ST_JUMP: begin
            jump_req <= 1'b1;
            jump_addr <= `SBL_RAM_BASE;
            state_reg <= ST_RUN;
          end
          ST_RUN: begin
            // Loaded code runs; mode stays set until a reset
            state_reg <= ST_RUN;
          end
          ST_CAN: begin
            // CAN frame handling lives elsewhere; this end only hands over
            state_reg <= ST_CAN;
          end
          default: begin
            state_reg <= ST_OFF;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/sbl_top_assertions.sv
// Concurrent checks on the boot loader sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sbl_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic boot_loader_mode,
  input wire logic watchdog_enable,
  input wire logic fetch_redirect,
  input wire logic ram_wr_en,
  input wire logic [23:0] ram_wr_addr,
  input wire logic jump_req,
  input wire logic [23:0] jump_addr,
  input wire logic exec_start,
  input wire logic can_boot_start,
  input wire logic serial_transmit_pin,
  input wire logic serial_transmit_oe,
  input wire logic tx_direction_bit,
  input wire logic [15:0] serial_control_reg,
  input wire logic [15:0] system_config_reg,
  input wire logic [15:0] stack_top_pointer
);
  logic [23:0] last_addr_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last store address, so each store can be tied to the one before
  always @(posedge aclk) begin
    if (!aresetn)
      last_addr_reg <= 24'h000000;
    else if (ram_wr_en)
      last_addr_reg <= ram_wr_addr;
  end
  wdog_off_a: assert property (watchdog_enable == !boot_loader_mode)
    else $error("watchdog enabled in boot mode");
  redirect_a: assert property (fetch_redirect == boot_loader_mode)
    else $error("fetch redirect does not follow boot mode");
  jump_target_a: assert property (jump_req |-> jump_addr == 24'h00fa40 && boot_loader_mode ##1 !jump_req)
    else $error("bad jump");
  ram_window_a: assert property (ram_wr_en |-> ram_wr_addr >= 24'h00fa40 && ram_wr_addr <= 24'h00fa5f)
    else $error("store outside load window");
  addr_step_a: assert property (ram_wr_en && ram_wr_addr != 24'h00fa40 |-> ram_wr_addr == last_addr_reg + 24'h000001)
    else $error("store address not sequential");
  config_forced_a: assert property ($rose(boot_loader_mode) |-> system_config_reg == 16'h0400 && stack_top_pointer == 16'hfa40)
    else $error("configuration not forced on entry");
  oe_config_a: assert property ($rose(serial_transmit_oe) |-> tx_direction_bit && serial_control_reg == 16'h8011)
    else $error("tx driven before serial setup");
  tx_idle_a: assert property (!serial_transmit_oe |-> serial_transmit_pin)
    else $error("tx not idle while undriven");
  exit_pulse_a: assert property (exec_start |=> !exec_start && !boot_loader_mode)
    else $error("bad exit pulse");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property (jump_req);
  cover property (exec_start);
  cover property (can_boot_start);
endmodule
bind sbl_top sbl_top_checker sbl_top_checker_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .boot_loader_mode, .watchdog_enable, .fetch_redirect, .ram_wr_en, .ram_wr_addr,
  .jump_req, .jump_addr, .exec_start, .can_boot_start, .serial_transmit_pin, .serial_transmit_oe,
  .tx_direction_bit, .serial_control_reg, .system_config_reg, .stack_top_pointer);
`default_nettype wire

// ### bench/sbl_host_model.sv
// Host side of the serial boot link: sends bytes, catches the acknowledge
`timescale 1ns/1ps
`default_nettype none
module sbl_host_model #(
  parameter int BIT_CLK = 64
) (
  input wire logic aclk,
  output logic rx_line,
  input wire logic tx_line,
  input wire logic tx_oe,
  output logic [7:0] ack_byte,
  output logic ack_done
);
  // One frame, start low, LSB first, one stop bit; line stays high after
  task send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rx_line <= fr[k];
      repeat (BIT_CLK) @(posedge aclk);
    end
  endtask
  // Receiver for the acknowledge, sampled mid bit
  initial begin
    rx_line = 1'b1;
    ack_done = 1'b0;
    ack_byte = 8'h00;
    forever begin
      @(negedge aclk);
      // Nothing is expected on tx until the device enables it
      if (tx_oe === 1'b1 && tx_line === 1'b0 && !ack_done) begin
        repeat (BIT_CLK / 2) @(negedge aclk);
        for (int k = 0; k < 8; k++) begin
          repeat (BIT_CLK) @(negedge aclk);
          ack_byte[k] = tx_line;
        end
        repeat (BIT_CLK) @(negedge aclk);
        ack_done = tx_line; // Stop bit must be high
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/serial_boot_loader_sequencer_test.sv
// Self-checking bench for the serial boot loader sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sbl_defines.vh"
module serial_boot_loader_sequencer_test;
  localparam int TXDLY = 200; // Short delay keeps the run brief
  localparam logic [7:0] ACK = 8'h3c; // Arbitrary value
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, q;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic boot_select_pin = 0, external_access_select = 1, can_receive_pin = 1;
  logic [1:0] r;
  logic [7:0] ack_byte;
  logic ack_done;
  wire serial_receive_pin, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  wire serial_transmit_pin, serial_transmit_oe, boot_loader_mode, watchdog_enable, fetch_redirect;
  wire ram_wr_en, jump_req, exec_start, exec_from_external, can_boot_start, tx_direction_bit;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] ram_wr_addr, jump_addr;
  wire [7:0] ram_wr_data;
  wire [15:0] system_config_reg, context_base_pointer, stack_top_pointer, stack_underflow_limit;
  wire [15:0] stack_overflow_limit, serial_control_reg, baud_generator_reg;
  int miscompares = 0, checks = 0, wr_cnt = 0, jump_cnt = 0, exec_cnt = 0, can_cnt = 0, n;
  logic [31:0] row_addr [0:7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h0, 32'h4, 32'h20};
  logic row_wr [0:7] = '{0, 0, 0, 0, 0, 1, 1, 1};
  logic [1:0] row_resp [0:7] = '{0, 0, 0, 0, 2, 0, 2, 2};
  logic [31:0] row_data [0:7] = '{32'h0, 32'h0002_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  sbl_top #(.TXDLY_CYC(TXDLY), .ACK_CODE(ACK)) sbl_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_select_pin,
    .external_access_select, .serial_receive_pin, .can_receive_pin, .serial_transmit_pin,
    .serial_transmit_oe, .boot_loader_mode, .watchdog_enable, .fetch_redirect, .ram_wr_en,
    .ram_wr_addr, .ram_wr_data, .jump_req, .jump_addr, .exec_start, .exec_from_external,
    .can_boot_start, .system_config_reg, .context_base_pointer, .stack_top_pointer,
    .stack_underflow_limit, .stack_overflow_limit, .serial_control_reg, .baud_generator_reg,
    .tx_direction_bit);
  sbl_host_model #(.BIT_CLK(64)) host_i (.aclk(aclk), .rx_line(serial_receive_pin),
    .tx_line(serial_transmit_pin), .tx_oe(serial_transmit_oe), .ack_byte(ack_byte),
    .ack_done(ack_done));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task ck(input bit ok, input string m);
    checks++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task close_out;
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] pat(int i);
    return i[7:0] * 8'h25 + 8'h0b;
  endfunction
  // Reset held 8 cycles so the pin synchronisers carry the straps
  task hw_reset(input logic b, input logic e);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_select_pin <= b;
    external_access_select <= e;
    can_receive_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // One bus cycle; ready and valid are looked at before the edge that takes them
  task axi(input logic wr, input logic [31:0] a, input logic [31:0] d);
    bit aw, w, ar, done;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!done);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // Pulse and store monitor, sampled mid cycle
  always @(negedge aclk) begin
    if (ram_wr_en === 1'b1) begin
      ck(ram_wr_addr === 24'h00fa40 + wr_cnt[23:0] && ram_wr_data === pat(wr_cnt), "store");
      wr_cnt++;
    end
    jump_cnt += int'(jump_req === 1'b1);
    exec_cnt += int'(exec_start === 1'b1);
    can_cnt += int'(can_boot_start === 1'b1);
  end
  initial begin
    repeat (50000) @(posedge aclk);
    miscompares++;
    close_out;
  end
  initial begin
    hw_reset(1'b0, 1'b1);
    ck(boot_loader_mode === 1'b1 && watchdog_enable === 1'b0 && fetch_redirect === 1'b1, "entry");
    ck(system_config_reg === 16'h0400 && context_base_pointer === 16'hfa00 &&
      stack_top_pointer === 16'hfa40 && stack_underflow_limit === 16'hfa00 &&
      stack_overflow_limit === 16'hfc00, "forced config");
    for (int i = 0; i < 8; i++) begin
      axi(row_wr[i], row_addr[i], 32'h0);
      ck(r === row_resp[i] && (row_wr[i] || q === row_data[i]), "register response");
    end
    repeat (40) @(posedge aclk);
    host_i.send_byte(8'h00);
    ck(serial_control_reg === 16'h8011 && baud_generator_reg === 16'h0001 &&
      tx_direction_bit === 1'b1, "serial setup");
    ck(serial_transmit_oe === 1'b0, "tx driven early");
    n = 0;
    while (serial_transmit_oe !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    ck(n > TXDLY - 80 && n < TXDLY, "tx delay");
    n = 0;
    while (ack_done !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    ck(ack_done === 1'b1 && ack_byte === ACK, "acknowledge");
    axi(1'b0, 32'h8, 32'h0);
    ck(q === 32'h0000_0001 && r === 2'h0, "reload read");
    axi(1'b0, 32'hc, 32'h0);
    ck(q >= 32'd108 && q <= 32'd179 && r === 2'h0, "measured count");
    repeat (64) @(posedge aclk);
    for (int i = 0; i < 33; i++) host_i.send_byte(pat(i));
    repeat (20) @(posedge aclk);
    ck(wr_cnt == 32 && jump_cnt == 1 && boot_loader_mode === 1'b1, "load and jump");
    axi(1'b0, 32'h4, 32'h0);
    ck(q === 32'h0080_2001 && r === 2'h0, "status after load");
    axi(1'b1, 32'h0, 32'h1);
    repeat (4) @(posedge aclk);
    ck(boot_loader_mode === 1'b0 && watchdog_enable === 1'b1 && exec_cnt == 1 &&
      exec_from_external === 1'b0, "software exit");
    hw_reset(1'b1, 1'b0);
    ck(boot_loader_mode === 1'b0 && exec_cnt == 2 && exec_from_external === 1'b1, "hw exit");
    hw_reset(1'b0, 1'b0);
    axi(1'b1, 32'h0, 32'h3);
    repeat (6) @(posedge aclk);
    ck(boot_loader_mode === 1'b1, "degraded reset left mode");
    boot_select_pin <= 1'b1;
    axi(1'b1, 32'h0, 32'h3);
    repeat (6) @(posedge aclk);
    ck(boot_loader_mode === 1'b0, "degraded exit");
    hw_reset(1'b0, 1'b1);
    can_receive_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    ck(can_cnt == 1 && serial_transmit_oe === 1'b0, "can start");
    close_out;
  end
endmodule
`default_nettype wire
